// [src/sie_pkg.sv]
// Package for the interrupt and DMA enable block of the serial port.
// Assumes one 25 MHz clock and an AHB-Lite slave register port.
`default_nettype none
package sie_pkg;
  // Register byte offsets
  localparam logic [7:0] SIE_OFS_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] SIE_OFS_EVT_STATUS = 8'h04;
  localparam logic [7:0] SIE_OFS_CONTROL = 8'h08;
  // Field positions in the enable register
  localparam int SIE_BIT_FLOAT = 24;
  localparam int SIE_BIT_DMA = 16;
  localparam int SIE_BIT_TX = 9;
  localparam int SIE_BIT_RX = 8;
  localparam int SIE_BIT_OVR = 6;
  localparam int SIE_BIT_BIT = 4;
  localparam int SIE_BIT_DSY = 3;
  localparam int SIE_BIT_PAR = 2;
  localparam int SIE_BIT_TMO = 1;
  localparam int SIE_BIT_DLE = 0;
  // Writable mask and reset value of the enable register
  localparam logic [31:0] SIE_IEN_MASK = 32'h0101_035f;
  localparam logic [31:0] SIE_IEN_RESET = 32'h0000_0000;
  // Control register fields
  localparam int SIE_BIT_GEN = 0;
  localparam int SIE_BIT_MST = 1;
  localparam int SIE_BIT_MON = 2;
  localparam logic [31:0] SIE_CTL_MASK = 32'h0000_0007;
  localparam logic [31:0] SIE_CTL_RESET = 32'h0000_0000;
  // Number of event sources
  localparam int SIE_NEVT = 8;
  // AHB encodings
  localparam logic [1:0] SIE_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] SIE_HTRANS_SEQ = 2'h3;
endpackage : sie_pkg
`default_nettype wire

// [src/sie_gate.sv]
// Gates the event flags by their enables into one interrupt line.
// Assumes flags are levels held by the flag register outside.
`default_nettype none
module sie_gate (
  // Flags and enables
  input wire logic [7:0] flags,
  input wire logic [7:0] enables,
  // Gated result
  output logic [7:0] gated,
  output logic any
);
  import sie_pkg::*;
  // One AND per event
  genvar gi;
  generate
    for (gi = 0; gi < SIE_NEVT; gi++) begin : g_evt
      assign gated[gi] = flags[gi] & enables[gi];
    end
  endgenerate
  assign any = |gated;
endmodule : sie_gate
`default_nettype wire

// [src/sie_wait_pin.sv]
// Drives the slave wait pin, high or floated when idle.
// Assumes the shift engine supplies the wait level and the pin use.
`default_nettype none
module sie_wait_pin (
  // Configuration
  input wire logic float_en,
  input wire logic pin_is_wait,
  // Wait request, high means hold off
  input wire logic wait_low,
  // Pin signals
  output logic pin_o,
  output logic pin_oe
);
  // Low when waiting, else high or released
  always_comb begin
    pin_o = ~wait_low;
    pin_oe = pin_is_wait & (wait_low | ~float_en);
  end
endmodule : sie_wait_pin
`default_nettype wire

// [src/sie_top.sv]
// Interrupt enable and DMA request block of the serial port.
// Assumes AHB-Lite single word transfers and one clock mclk.
// Functional notes
// - Reserved enable bits read zero and ignore writes.
// - Float enable set: wait pin floats whenever not driving low.
// - Float enable clear: wait pin driven high when inactive.
// - DMA enable gates both receive and transmit requests.
// - One transmit request per word moved into shift register.
// - One receive request per word copied into receive buffer.
// - Transmit enable gates transmit-ready flag onto interrupt.
// - Transmit-ready raised at every shift register load.
// - Receive enable gates receive-full flag onto interrupt.
// - Overrun enable gates overrun flag onto interrupt.
// - Enable fields read/write, reset zero; reserved read zero.
// - Bit-error enable gates bit-error flag onto interrupt.
// - Desync enable acts only in master mode with monitor active.
// - Parity enable gates parity-error flag onto interrupt.
//
// Our own choices: register access over AHB-Lite and the address map.
`default_nettype none
module sie_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Event flags from the flag register
  input wire logic rx_full_flag,
  input wire logic overrun_flag,
  input wire logic bit_error_flag,
  input wire logic desync_flag,
  input wire logic parity_error_flag,
  input wire logic timeout_flag,
  input wire logic length_error_flag,
  // Buffer transfer strobes from the shift engine
  input wire logic shift_load,
  input wire logic rx_copy,
  input wire logic tx_ready_clear,
  // Wait pin use and request
  input wire logic pin_is_wait,
  input wire logic wait_low,
  // Outputs to interrupt and DMA controllers
  output logic irq,
  output logic tx_dma_req,
  output logic rx_dma_req,
  // Slave wait pin
  output logic slave_wait_pin_o,
  output logic slave_wait_pin_oe,
  // Transmit-ready state
  output logic tx_ready_flag
);
  import sie_pkg::*;

  logic [31:0] ien_ff;
  logic [31:0] ctl_ff;
  logic tx_ready_ff;
  logic tx_dma_ff;
  logic rx_dma_ff;
  logic irq_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] rdata_ff;
  logic [7:0] flags;
  logic [7:0] enables;
  logic [7:0] gated;
  logic any_irq;
  logic xfer;
  logic dsy_allowed;
  logic [31:0] nxt_rdata;

  // Accepted address phase
  assign xfer = hsel & hready &
    (htrans == SIE_HTRANS_NONSEQ || htrans == SIE_HTRANS_SEQ);

  // Capture write address for the data phase
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= xfer & hwrite;
      if (xfer) begin
        wr_addr_ff <= haddr[7:0];
      end
    end
  end

  // Enable register write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ien_ff <= SIE_IEN_RESET;
    end else if (wr_pend_ff && wr_addr_ff == SIE_OFS_IRQ_ENABLE) begin
      ien_ff <= hwdata & SIE_IEN_MASK;
    end
  end

  // Control register write, global enable and mode bits
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_ff <= SIE_CTL_RESET;
    end else if (wr_pend_ff && wr_addr_ff == SIE_OFS_CONTROL) begin
      ctl_ff <= hwdata & SIE_CTL_MASK;
    end
  end

  // Read data chosen in the address phase
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (haddr[7:0])
      SIE_OFS_IRQ_ENABLE: nxt_rdata = ien_ff;
      SIE_OFS_EVT_STATUS: nxt_rdata = {16'h0000, gated, flags};
      SIE_OFS_CONTROL: nxt_rdata = ctl_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (xfer && !hwrite) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Zero wait states, always OKAY
  assign hrdata = rdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Transmit-ready flag, a load wins over a clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready_ff <= 1'b0;
    end else if (shift_load) begin
      tx_ready_ff <= 1'b1;
    end else if (tx_ready_clear) begin
      tx_ready_ff <= 1'b0;
    end
  end
  assign tx_ready_flag = tx_ready_ff;

  // Desync monitor only meaningful in master with monitor option
  // master mode only
  assign dsy_allowed = ctl_ff[SIE_BIT_MST] & ctl_ff[SIE_BIT_MON];

  // Flag and enable vectors, same order
  assign flags = {tx_ready_ff, rx_full_flag, overrun_flag,
    bit_error_flag, desync_flag, parity_error_flag, timeout_flag,
    length_error_flag};
  assign enables = {ien_ff[SIE_BIT_TX], ien_ff[SIE_BIT_RX],
    ien_ff[SIE_BIT_OVR], ien_ff[SIE_BIT_BIT],
    ien_ff[SIE_BIT_DSY] & dsy_allowed, ien_ff[SIE_BIT_PAR],
    ien_ff[SIE_BIT_TMO], ien_ff[SIE_BIT_DLE]};

  sie_gate u_gate (
    .flags(flags),
    .enables(enables),
    .gated(gated),
    .any(any_irq)
  );

  // Registered interrupt line
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= any_irq;
    end
  end
  assign irq = irq_ff;

  // DMA request pulses, one per transfer strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_dma_ff <= 1'b0;
      rx_dma_ff <= 1'b0;
    end else begin
      // relies on global enable set first
      tx_dma_ff <= ien_ff[SIE_BIT_DMA] & ctl_ff[SIE_BIT_GEN] & shift_load;
      rx_dma_ff <= ien_ff[SIE_BIT_DMA] & ctl_ff[SIE_BIT_GEN] & rx_copy;
    end
  end
  assign tx_dma_req = tx_dma_ff;
  assign rx_dma_req = rx_dma_ff;

  sie_wait_pin u_wait (
    .float_en(ien_ff[SIE_BIT_FLOAT]),
    .pin_is_wait(pin_is_wait),
    .wait_low(wait_low),
    .pin_o(slave_wait_pin_o),
    .pin_oe(slave_wait_pin_oe)
  );
endmodule : sie_top
`default_nettype wire

// [bench/sie_far.sv]
// Stand-in for the DMA controller: counts transmit and receive requests.
// Assumes each request is a pulse of one mclk cycle.
`default_nettype none
module sie_far (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Requests from the block
  input wire logic tx_dma_req,
  input wire logic rx_dma_req,
  // Requests seen
  output int tx_cnt,
  output int rx_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // One count per request cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_cnt <= 0;
      rx_cnt <= 0;
    end else begin
      tx_cnt <= tx_cnt + int'(tx_dma_req);
      rx_cnt <= rx_cnt + int'(rx_dma_req);
    end
  end
endmodule : sie_far
`default_nettype wire

// [bench/sie_assertions.sv]
// Checker of the enable block, watching the top module's ports.
// Assumes mclk and an active-low rst_n driven by the bench.
`default_nettype none
module sie_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Strobes and pin requests
  input wire logic shift_load,
  input wire logic rx_copy,
  input wire logic tx_ready_clear,
  input wire logic pin_is_wait,
  input wire logic wait_low,
  // Outputs watched
  input wire logic tx_dma_req,
  input wire logic rx_dma_req,
  input wire logic slave_wait_pin_o,
  input wire logic slave_wait_pin_oe,
  input wire logic tx_ready_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  tx_dma_a: assert property (tx_dma_req |-> $past(shift_load))
    else $error("tx request without load");
  rx_dma_a: assert property (rx_dma_req |-> $past(rx_copy))
    else $error("rx request without copy");
  tx_set_a: assert property (shift_load |=> tx_ready_flag)
    else $error("ready not set by load");
  tx_clr_a: assert property (tx_ready_clear && !shift_load
    |=> !tx_ready_flag) else $error("ready not cleared");
  tx_hold_a: assert property (tx_ready_flag && !tx_ready_clear
    |=> tx_ready_flag) else $error("ready dropped alone");
  wait_low_a: assert property (pin_is_wait && wait_low
    |-> slave_wait_pin_oe && !slave_wait_pin_o) else $error("pin not low");
  wait_high_a: assert property (slave_wait_pin_oe && !wait_low
    |-> slave_wait_pin_o) else $error("pin not high");
  pin_off_a: assert property (!pin_is_wait |-> !slave_wait_pin_oe)
    else $error("pin driven while unused");
endmodule : sie_chk
bind sie_top sie_chk i_chk (.mclk, .rst_n, .shift_load, .rx_copy,
  .tx_ready_clear, .pin_is_wait, .wait_low, .tx_dma_req, .rx_dma_req,
  .slave_wait_pin_o, .slave_wait_pin_oe, .tx_ready_flag);
`default_nettype wire

// [bench/tb_spi_interrupt_dma_enable.sv]
// Bench: registers, flag rows, DMA, ready and wait pin cases.
// Assumes the far-side model and the bound checker.
`default_nettype none
module tb_spi_interrupt_dma_enable;
  timeunit 1ns;
  timeprecision 1ns;
  import sie_pkg::*;
  typedef struct packed {
    logic [31:0] en;
    logic [6:0] fl;
    logic [2:0] ctl;
    logic ex;
  } sie_row_s;
  // Enables, flags rx..dle, control, expected irq
  sie_row_s rows [10] = '{'{32'h100, 7'h40, 3'h0, 1'b1},
    '{32'h0, 7'h40, 3'h0, 1'b0}, '{32'h40, 7'h20, 3'h0, 1'b1},
    '{32'h10, 7'h10, 3'h0, 1'b1}, '{32'h8, 7'h08, 3'h7, 1'b1},
    '{32'h8, 7'h08, 3'h1, 1'b0}, '{32'h4, 7'h04, 3'h0, 1'b1},
    '{32'h2, 7'h02, 3'h0, 1'b1}, '{32'h1, 7'h01, 3'h0, 1'b1},
    '{32'h1, 7'h02, 3'h0, 1'b0}};
  logic mclk, rst_n, hsel, hwrite, hreadyout, hresp, irq, pw, wl;
  logic ld, cp, clr, tdr, rdr, pin_o, pin_oe, rdy;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [6:0] fl;
  int fail_count, n_compared, txc, rxc;
  sie_top i_dut (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .rx_full_flag(fl[6]), .overrun_flag(fl[5]), .bit_error_flag(fl[4]),
    .desync_flag(fl[3]), .parity_error_flag(fl[2]), .timeout_flag(fl[1]),
    .length_error_flag(fl[0]), .shift_load(ld), .rx_copy(cp),
    .tx_ready_clear(clr), .pin_is_wait(pw), .wait_low(wl), .irq,
    .tx_dma_req(tdr), .rx_dma_req(rdr), .slave_wait_pin_o(pin_o),
    .slave_wait_pin_oe(pin_oe), .tx_ready_flag(rdy));
  sie_far i_far (.mclk, .rst_n, .tx_dma_req(tdr), .rx_dma_req(rdr),
    .tx_cnt(txc), .rx_cnt(rxc));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [31:0] e, s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= SIE_HTRANS_NONSEQ;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic pulse(input logic [2:0] m, input int n);
    @(posedge mclk);
    {ld, cp, clr} <= m;
    repeat (n) @(posedge mclk);
    {ld, cp, clr} <= 3'h0;
    repeat (3) @(negedge mclk);
  endtask : pulse
  task automatic finish_test;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  initial begin
    #400000;
    fail_count++;
    finish_test();
  end
  initial begin
    {hsel, hwrite, ld, cp, clr, pw, wl, haddr, hwdata, htrans, fl} = '0;
    {fail_count, n_compared, hsize, rst_n} = {32'h0, 32'h0, 3'h2, 1'b0};
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    hsel <= 1'b1;
    bus(1'b0, SIE_OFS_IRQ_ENABLE, 32'h0);
    chk("ien reset", SIE_IEN_RESET, q);
    bus(1'b1, SIE_OFS_IRQ_ENABLE, 32'hffff_ffff);
    bus(1'b0, SIE_OFS_IRQ_ENABLE, 32'h0);
    chk("ien mask", SIE_IEN_MASK, q);
    $display("test registers done");
    foreach (rows[i]) begin
      bus(1'b1, SIE_OFS_CONTROL, {29'h0, rows[i].ctl});
      bus(1'b1, SIE_OFS_IRQ_ENABLE, rows[i].en);
      fl <= rows[i].fl;
      repeat (3) @(negedge mclk);
      chk("irq row", {31'h0, rows[i].ex}, {31'h0, irq});
      @(posedge mclk);
      fl <= 7'h0;
    end
    $display("test flag rows done");
    bus(1'b1, SIE_OFS_CONTROL, 32'h1);
    bus(1'b1, SIE_OFS_IRQ_ENABLE, 32'h0001_0000);
    pulse(3'h4, 1);
    pulse(3'h2, 2);
    chk("tx dma", 32'h1, txc);
    chk("rx dma", 32'h2, rxc);
    chk("ready", 32'h1, {31'h0, rdy});
    bus(1'b1, SIE_OFS_IRQ_ENABLE, 32'h0000_0200);
    pulse(3'h6, 1);
    chk("tx irq", 32'h1, {31'h0, irq});
    chk("dma off", 32'h3, txc + rxc);
    bus(1'b0, SIE_OFS_EVT_STATUS, 32'h0);
    chk("status", 32'h0000_8080, q);
    pulse(3'h1, 1);
    chk("irq clr", 32'h0, {31'h0, irq});
    bus(1'b1, SIE_OFS_IRQ_ENABLE, 32'h0);
    pulse(3'h4, 1);
    chk("irq off", 32'h0, {31'h0, irq});
    $display("test dma and ready done");
    @(posedge mclk);
    pw <= 1'b1;
    @(negedge mclk);
    chk("pin high", 32'h3, {30'h0, pin_oe, pin_o});
    bus(1'b1, SIE_OFS_IRQ_ENABLE, 32'h0100_0000);
    @(negedge mclk);
    chk("pin float", 32'h0, {31'h0, pin_oe});
    @(posedge mclk);
    wl <= 1'b1;
    @(negedge mclk);
    chk("pin low", 32'h2, {30'h0, pin_oe, pin_o});
    $display("test wait pin done");
    // Reset in mid-run clears enables, ready, requests and interrupt
    bus(1'b1, SIE_OFS_IRQ_ENABLE, 32'h0001_0200);
    pulse(3'h4, 1);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk("reset out", 32'h0, {28'h0, hresp, irq, rdy, tdr});
    bus(1'b0, SIE_OFS_IRQ_ENABLE, 32'h0);
    chk("ien rst", SIE_IEN_RESET, q);
    bus(1'b1, 8'h0c, 32'hffff_ffff);
    bus(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
    finish_test();
  end
endmodule : tb_spi_interrupt_dma_enable
`default_nettype wire
